// file: hdl/vfs_defines.svh
// constants for the video frame scaler: widths, packet codes, sizes
`ifndef VFS_DEFINES_SVH
`define VFS_DEFINES_SVH
`define VFS_DATA_W 8
`define VFS_DIM_W 16
`define VFS_MAX_W 2048
`define VFS_ADDR_W 11
`define VFS_BFH 4
`define VFS_BFV 3
`define VFS_FRAC_W (`VFS_BFH + `VFS_BFV)
`define VFS_MUL_W ((`VFS_FRAC_W + 2) > `VFS_DATA_W ? (`VFS_FRAC_W + 2) : `VFS_DATA_W)
`define VFS_TYPE_CTRL 4'hF
`define VFS_TYPE_VIDEO 4'h0
`define VFS_CNT_W 16
`define VFS_CTRL_LAST 16'h0003
`define VFS_HDR_LAST 16'h0005
`define VFS_HDR_EOP 16'h0004
`define VFS_ONE 16'h0001
`define VFS_W 34
`endif

// file: hdl/vfs_pkg.sv
// types shared by the video frame scaler
package vfs_pkg;
    typedef enum logic [1:0] {
        VFS_NEAREST = 2'b00,
        VFS_BILINEAR = 2'b01,
        VFS_BICUBIC = 2'b10,
        VFS_POLYPHASE = 2'b11
    } vfs_mode_t;
    typedef enum logic [2:0] {
        VFS_IDLE = 3'b000,
        VFS_CTRL = 3'b001,
        VFS_SKIP = 3'b010,
        VFS_OHDR = 3'b011,
        VFS_LOAD = 3'b100,
        VFS_EMIT = 3'b101,
        VFS_DRAIN = 3'b110
    } vfs_state_t;
endpackage

// file: hdl/vfs_scaler.sv
// streaming video resizer: control packet parsing, line buffers, interpolation
`timescale 1ns/1ps
`include "vfs_defines.svh"
// Summary of operation
// - four methods selectable; cubic ones use bilinear
// - input size taken from control packets
// - output size sampled at each frame start
// - nearest: truncated doubled-numerator source index
// - nearest uses a single line buffer
// - nearest copies pixels unblended; the blend sum is still built but not selected
// - bilinear uses four pixel multipliers
// - multiplier width: max(data, fractions plus two)
// - bilinear keeps two clipped line buffers
// - bilinear source position i*w_in/w_out
// - error fraction scaled by max dimension
// - four neighbours weighted, sum scaled back
module vfs_scaler #(
    parameter vfs_pkg::vfs_mode_t MODE = vfs_pkg::VFS_BILINEAR
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [`VFS_DIM_W-1:0] cfg_out_w,
    input wire logic [`VFS_DIM_W-1:0] cfg_out_h,
    input wire logic [`VFS_DATA_W-1:0] din_data,
    input wire logic din_valid,
    input wire logic din_sop,
    input wire logic din_eop,
    output logic din_ready,
    output logic [`VFS_DATA_W-1:0] dout_data,
    output logic dout_valid,
    output logic dout_sop,
    output logic dout_eop,
    input wire logic dout_ready
);
    import vfs_pkg::*;

    // method is a build-time constant, so it cannot move mid-frame
    localparam bit IS_NN = (MODE == VFS_NEAREST);
    localparam int MW = `VFS_MUL_W; // multiplier operand width
    localparam int PW = 2 * MW; // product width

    vfs_state_t state_r, state_nxt; // frame sequencer
    logic [`VFS_DIM_W-1:0] w_in_r, w_in_nxt; // input width from stream
    logic [`VFS_DIM_W-1:0] h_in_r, h_in_nxt; // input height from stream
    logic [`VFS_DIM_W-1:0] w_out_r, w_out_nxt; // output width for this frame
    logic [`VFS_DIM_W-1:0] h_out_r, h_out_nxt; // output height for this frame
    logic [`VFS_CNT_W-1:0] cnt_r, cnt_nxt; // word or column counter
    logic [`VFS_DIM_W-1:0] row_r, row_nxt; // newest loaded input row
    logic [`VFS_DIM_W-1:0] oi_r, oi_nxt; // output column
    logic [`VFS_DIM_W-1:0] oj_r, oj_nxt; // output row
    logic in_end_r, in_end_nxt; // input frame already ended
    logic din_ready_r, din_ready_nxt;
    logic [`VFS_DATA_W-1:0] dout_data_r, dout_data_nxt;
    logic dout_valid_r, dout_valid_nxt;
    logic dout_sop_r, dout_sop_nxt;
    logic dout_eop_r, dout_eop_nxt;

    // line storage: two banks, the nearest method only ever touches bank 0
    logic [`VFS_DATA_W-1:0] lbuf [0:1][0:`VFS_MAX_W-1];
    logic wr_en; // line write strobe
    logic wr_bank; // bank being filled

    logic acc; // input word taken this cycle
    logic can_out; // output register free
    assign acc = din_valid && din_ready_r;
    assign can_out = !dout_valid_r || dout_ready;

    // source position and error terms for the current output pixel
    logic [`VFS_W-1:0] hnum, hden, hq, hrem, vnum, vden, vq, vrem, hmax, vmax;
    logic [`VFS_DIM_W-1:0] col_c, col_n, row_c, row_n, need;
    logic [`VFS_BFH:0] ei, wx0;
    logic [`VFS_BFV:0] ej, wy0;
    logic [MW-1:0] w00, w10, w01, w11;
    logic [`VFS_DATA_W-1:0] p00, p10, p01, p11, pix;
    logic [PW+1:0] bsum;
    logic top_b, bot_b;

    // coordinate mapping; the wide divides keep this a one-cycle lookup
    always_comb
    begin
        if (IS_NN)
        begin
            // doubled numerator rounds to the nearest pixel centre
            hnum = (`VFS_W'(oi_r) * `VFS_W'(w_in_r) << 1) + `VFS_W'(w_in_r);
            hden = `VFS_W'(w_out_r) << 1;
            vnum = (`VFS_W'(oj_r) * `VFS_W'(h_in_r) << 1) + `VFS_W'(h_in_r);
            vden = `VFS_W'(h_out_r) << 1;
        end
        else
        begin
            hnum = `VFS_W'(oi_r) * `VFS_W'(w_in_r);
            hden = `VFS_W'(w_out_r);
            vnum = `VFS_W'(oj_r) * `VFS_W'(h_in_r);
            vden = `VFS_W'(h_out_r);
        end
        hq = hnum / hden;
        hrem = hnum % hden;
        vq = vnum / vden;
        vrem = vnum % vden;
        // clamp at the right and bottom edges so neighbours stay in range
        col_c = (hq >= `VFS_W'(w_in_r)) ? w_in_r - `VFS_ONE : hq[`VFS_DIM_W-1:0];
        row_c = (vq >= `VFS_W'(h_in_r)) ? h_in_r - `VFS_ONE : vq[`VFS_DIM_W-1:0];
        col_n = (col_c == w_in_r - `VFS_ONE) ? col_c : col_c + `VFS_ONE;
        row_n = (row_c == h_in_r - `VFS_ONE) ? row_c : row_c + `VFS_ONE;
        hmax = (w_in_r > w_out_r) ? `VFS_W'(w_in_r) : `VFS_W'(w_out_r);
        vmax = (h_in_r > h_out_r) ? `VFS_W'(h_in_r) : `VFS_W'(h_out_r);
        ei = (`VFS_BFH+1)'((hrem << `VFS_BFH) / hmax);
        ej = (`VFS_BFV+1)'((vrem << `VFS_BFV) / vmax);
        // nearest needs only its row; bilinear needs the row below too
        need = IS_NN ? row_c : row_n;
        top_b = IS_NN ? 1'b0 : row_c[0];
        bot_b = IS_NN ? 1'b0 : row_n[0];
    end

    // four-tap blend; the nearest method takes p00 untouched
    always_comb
    begin
        p00 = lbuf[top_b][col_c[`VFS_ADDR_W-1:0]];
        p10 = lbuf[top_b][col_n[`VFS_ADDR_W-1:0]];
        p01 = lbuf[bot_b][col_c[`VFS_ADDR_W-1:0]];
        p11 = lbuf[bot_b][col_n[`VFS_ADDR_W-1:0]];
        wx0 = (`VFS_BFH+1)'(1 << `VFS_BFH) - ei;
        wy0 = (`VFS_BFV+1)'(1 << `VFS_BFV) - ej;
        w00 = MW'(wx0 * wy0);
        w10 = MW'(ei * wy0);
        w01 = MW'(wx0 * ej);
        w11 = MW'(ei * ej);
        // exactly four data multipliers per parallel channel
        bsum = (PW+2)'(MW'(p00) * w00) + (PW+2)'(MW'(p10) * w10)
             + (PW+2)'(MW'(p01) * w01) + (PW+2)'(MW'(p11) * w11);
        // the blending sum is built for nearest too, but only p00 is selected
        pix = IS_NN ? p00 : bsum[`VFS_FRAC_W +: `VFS_DATA_W];
    end

    // frame sequencer: parse, announce, load rows, emit rows, drain
    always_comb
    begin
        state_nxt = state_r;
        w_in_nxt = w_in_r;
        h_in_nxt = h_in_r;
        w_out_nxt = w_out_r;
        h_out_nxt = h_out_r;
        cnt_nxt = cnt_r;
        row_nxt = row_r;
        oi_nxt = oi_r;
        oj_nxt = oj_r;
        in_end_nxt = in_end_r;
        dout_data_nxt = dout_data_r;
        dout_valid_nxt = dout_valid_r && !dout_ready;
        dout_sop_nxt = dout_sop_r;
        dout_eop_nxt = dout_eop_r;
        wr_en = 1'b0;
        wr_bank = IS_NN ? 1'b0 : row_r[0];
        case (state_r)
            VFS_IDLE:
            begin
                cnt_nxt = '0;
                if (acc && din_sop && din_data[3:0] == `VFS_TYPE_CTRL && !din_eop)
                    state_nxt = VFS_CTRL;
                else if (acc && din_sop && din_data[3:0] == `VFS_TYPE_VIDEO && !din_eop)
                begin
                    // output size only moves between frames
                    w_out_nxt = cfg_out_w;
                    h_out_nxt = cfg_out_h;
                    in_end_nxt = 1'b0;
                    state_nxt = VFS_OHDR;
                end
                else if (acc && din_sop && !din_eop)
                    state_nxt = VFS_SKIP; // other packets are discarded
            end
            VFS_CTRL:
            begin
                if (acc)
                begin
                    // width then height, high byte first
                    case (cnt_r[1:0])
                        2'h0: w_in_nxt[15:8] = din_data;
                        2'h1: w_in_nxt[7:0] = din_data;
                        2'h2: h_in_nxt[15:8] = din_data;
                        default: h_in_nxt[7:0] = din_data;
                    endcase
                    cnt_nxt = cnt_r + `VFS_ONE;
                    if (din_eop)
                        state_nxt = VFS_IDLE;
                    else if (cnt_r == `VFS_CTRL_LAST)
                        state_nxt = VFS_SKIP;
                end
            end
            VFS_SKIP, VFS_DRAIN:
            begin
                if (acc && din_eop)
                    state_nxt = VFS_IDLE;
            end
            VFS_OHDR:
            begin
                if (can_out)
                begin
                    // control packet with output size, then video header
                    dout_valid_nxt = 1'b1;
                    dout_sop_nxt = (cnt_r == '0) || (cnt_r == `VFS_HDR_LAST);
                    dout_eop_nxt = (cnt_r == `VFS_HDR_EOP);
                    case (cnt_r[2:0])
                        3'h0: dout_data_nxt = `VFS_DATA_W'(`VFS_TYPE_CTRL);
                        3'h1: dout_data_nxt = w_out_r[15:8];
                        3'h2: dout_data_nxt = w_out_r[7:0];
                        3'h3: dout_data_nxt = h_out_r[15:8];
                        3'h4: dout_data_nxt = h_out_r[7:0];
                        default: dout_data_nxt = `VFS_DATA_W'(`VFS_TYPE_VIDEO);
                    endcase
                    cnt_nxt = cnt_r + `VFS_ONE;
                    if (cnt_r == `VFS_HDR_LAST)
                    begin
                        cnt_nxt = '0;
                        row_nxt = '0;
                        oi_nxt = '0;
                        oj_nxt = '0;
                        state_nxt = VFS_LOAD;
                    end
                end
            end
            VFS_LOAD:
            begin
                if (acc)
                begin
                    // one clipped input line per bank
                    wr_en = (cnt_r < `VFS_MAX_W);
                    cnt_nxt = cnt_r + `VFS_ONE;
                    in_end_nxt = din_eop;
                    if (cnt_r == w_in_r - `VFS_ONE || din_eop)
                    begin
                        cnt_nxt = '0;
                        state_nxt = VFS_EMIT;
                    end
                end
            end
            VFS_EMIT:
            begin
                if (need > row_r && !in_end_r)
                begin
                    // the rows this output row reads are not all here yet
                    row_nxt = row_r + `VFS_ONE;
                    state_nxt = VFS_LOAD;
                end
                else if (can_out)
                begin
                    // raster order, eop on the final pixel
                    dout_valid_nxt = 1'b1;
                    dout_sop_nxt = 1'b0;
                    dout_data_nxt = pix;
                    dout_eop_nxt = (oi_r == w_out_r - `VFS_ONE) && (oj_r == h_out_r - `VFS_ONE);
                    oi_nxt = oi_r + `VFS_ONE;
                    if (oi_r == w_out_r - `VFS_ONE)
                    begin
                        oi_nxt = '0;
                        oj_nxt = oj_r + `VFS_ONE;
                        if (oj_r == h_out_r - `VFS_ONE)
                            state_nxt = in_end_r ? VFS_IDLE : VFS_DRAIN;
                    end
                end
            end
            default:
                state_nxt = VFS_IDLE;
        endcase
        din_ready_nxt = (state_nxt != VFS_OHDR) && (state_nxt != VFS_EMIT);
    end

    // register stage for the sequencer and the output port
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_r <= VFS_IDLE;
            w_in_r <= `VFS_ONE;
            h_in_r <= `VFS_ONE;
            w_out_r <= `VFS_ONE;
            h_out_r <= `VFS_ONE;
            cnt_r <= '0;
            row_r <= '0;
            oi_r <= '0;
            oj_r <= '0;
            in_end_r <= 1'b0;
            din_ready_r <= 1'b0;
            dout_data_r <= '0;
            dout_valid_r <= 1'b0;
            dout_sop_r <= 1'b0;
            dout_eop_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            w_in_r <= w_in_nxt;
            h_in_r <= h_in_nxt;
            w_out_r <= w_out_nxt;
            h_out_r <= h_out_nxt;
            cnt_r <= cnt_nxt;
            row_r <= row_nxt;
            oi_r <= oi_nxt;
            oj_r <= oj_nxt;
            in_end_r <= in_end_nxt;
            din_ready_r <= din_ready_nxt;
            dout_data_r <= dout_data_nxt;
            dout_valid_r <= dout_valid_nxt;
            dout_sop_r <= dout_sop_nxt;
            dout_eop_r <= dout_eop_nxt;
        end
    end

    // line memory write; no reset so it maps onto block ram
    always_ff @(posedge mclk)
    begin
        if (wr_en)
            lbuf[wr_bank][cnt_r[`VFS_ADDR_W-1:0]] <= din_data;
    end

    assign din_ready = din_ready_r;
    assign dout_data = dout_data_r;
    assign dout_valid = dout_valid_r;
    assign dout_sop = dout_sop_r;
    assign dout_eop = dout_eop_r;

    // checks on the design's own behaviour
    ctrl_height_a: assert property (@(posedge mclk) disable iff (srst)
        (state_r == VFS_CTRL && acc && cnt_r == `VFS_CTRL_LAST) |=> h_in_r[7:0] == $past(din_data))
        else $error("input height not taken from control packet");
    out_size_a: assert property (@(posedge mclk) disable iff (srst)
        (state_r != VFS_IDLE) |=> $stable(w_out_r) && $stable(h_out_r))
        else $error("output size changed inside a frame");
    hdr_eop_a: assert property (@(posedge mclk) disable iff (srst)
        (state_r == VFS_OHDR && can_out && cnt_r == `VFS_HDR_EOP)
        |=> dout_eop_r && dout_valid_r && dout_data_r == h_out_r[7:0])
        else $error("control packet does not end with output height");
    nn_col_a: assert property (@(posedge mclk) disable iff (srst)
        (IS_NN && state_r == VFS_EMIT && hq < `VFS_W'(w_in_r))
        |-> hq * hden <= hnum && hnum < (hq + `VFS_W'(1)) * hden)
        else $error("nearest source column wrong");
    nn_pix_a: assert property (@(posedge mclk) disable iff (srst)
        (IS_NN && state_r == VFS_EMIT && can_out && !(need > row_r && !in_end_r))
        |=> dout_data_r == $past(p00))
        else $error("nearest output is not a copied input pixel");
    bil_err_a: assert property (@(posedge mclk) disable iff (srst)
        (!IS_NN && state_r == VFS_EMIT) |-> ei < (`VFS_BFH+1)'(1 << `VFS_BFH))
        else $error("horizontal error exceeds its fraction range");
    wsum_a: assert property (@(posedge mclk) disable iff (srst)
        (!IS_NN && state_r == VFS_EMIT)
        |-> (w00 + w10 + w01 + w11) == MW'(1 << `VFS_FRAC_W))
        else $error("bilinear weights do not sum to unity");
    emit_stall_a: assert property (@(posedge mclk) disable iff (srst)
        (state_r == VFS_EMIT) |-> !din_ready_r ##1 (state_r != VFS_EMIT || !din_ready_r))
        else $error("input accepted while line buffers are being read");
    last_eop_a: assert property (@(posedge mclk) disable iff (srst)
        (state_r == VFS_EMIT && dout_eop_nxt && dout_valid_nxt && !dout_sop_nxt && can_out)
        |=> dout_eop_r && (state_r == VFS_IDLE || state_r == VFS_DRAIN))
        else $error("frame end not flagged on last pixel");
endmodule // vfs_scaler

// file: tb/vfs_sink_model.sv
// downstream video sink model: random back-pressure, keeps every accepted word
`timescale 1ns/1ps
`include "vfs_defines.svh"
module vfs_sink_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [`VFS_DATA_W-1:0] dout_data,
    input wire logic dout_valid,
    input wire logic dout_sop,
    input wire logic dout_eop,
    output logic dout_ready,
    input wire logic [7:0] stall_pct
);
    // accepted words as {sop, eop, data}
    logic [`VFS_DATA_W+1:0] got[$];
    // ready moves at the falling edge so the design samples a settled level
    always @(negedge mclk)
    begin
        dout_ready <= srst ? 1'h0 : (($urandom % 100) >= stall_pct);
    end
    // a word counts only where valid and ready meet at a rising edge
    always @(posedge mclk)
    begin
        if (!srst && dout_valid && dout_ready)
        begin
            got.push_back({dout_sop, dout_eop, dout_data});
        end
    end
endmodule // vfs_sink_model

// file: tb/video_frame_scaler_tb.sv
// self-checking bench for the video frame scaler, bilinear and nearest builds side by side
`timescale 1ns/1ps
`include "vfs_defines.svh"
module video_frame_scaler_tb;
    import vfs_pkg::*;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic [`VFS_DIM_W-1:0] cfg_out_w = 16'h0001;
    logic [`VFS_DIM_W-1:0] cfg_out_h = 16'h0001;
    logic [`VFS_DATA_W-1:0] din_data = 8'h00;
    logic din_valid = 1'h0;
    logic din_sop = 1'h0;
    logic din_eop = 1'h0;
    logic din_ready;
    logic [`VFS_DATA_W-1:0] dout_data;
    logic dout_valid;
    logic dout_sop;
    logic dout_eop;
    logic dout_ready;
    logic use_nn = 1'h0; // steers the input stream to the nearest build
    logic din_ready_nn;
    logic [`VFS_DATA_W-1:0] dout_data_nn;
    logic dout_valid_nn;
    logic dout_sop_nn;
    logic dout_eop_nn;
    logic dout_ready_nn;
    logic [7:0] stall_pct = 8'h00; // sink back-pressure in percent
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] img[0:63]; // current input picture, raster order
    int wi, hi, wo, ho; // sizes of the frame under test
    int tw[6] = '{2, 3, 6, 4, 5, 8}; // corner sizes: walk, up, down, equal, odd
    int th[6] = '{1, 2, 4, 3, 3, 1};
    int tow[6] = '{2, 5, 3, 4, 7, 1};
    int toh[6] = '{1, 4, 2, 3, 2, 8};
    always #5 mclk = ~mclk;
    vfs_scaler #(.MODE(VFS_BILINEAR)) DUT (.mclk(mclk), .srst(srst), .cfg_out_w(cfg_out_w),
        .cfg_out_h(cfg_out_h), .din_data(din_data), .din_valid(din_valid && !use_nn),
        .din_sop(din_sop), .din_eop(din_eop), .din_ready(din_ready), .dout_data(dout_data),
        .dout_valid(dout_valid), .dout_sop(dout_sop), .dout_eop(dout_eop),
        .dout_ready(dout_ready));
    vfs_sink_model SINK (.mclk(mclk), .srst(srst), .dout_data(dout_data),
        .dout_valid(dout_valid), .dout_sop(dout_sop), .dout_eop(dout_eop),
        .dout_ready(dout_ready), .stall_pct(stall_pct));
    vfs_scaler #(.MODE(VFS_NEAREST)) DUT_NN (.mclk(mclk), .srst(srst), .cfg_out_w(cfg_out_w),
        .cfg_out_h(cfg_out_h), .din_data(din_data), .din_valid(din_valid && use_nn),
        .din_sop(din_sop), .din_eop(din_eop), .din_ready(din_ready_nn),
        .dout_data(dout_data_nn), .dout_valid(dout_valid_nn), .dout_sop(dout_sop_nn),
        .dout_eop(dout_eop_nn), .dout_ready(dout_ready_nn));
    vfs_sink_model SINKN (.mclk(mclk), .srst(srst), .dout_data(dout_data_nn),
        .dout_valid(dout_valid_nn), .dout_sop(dout_sop_nn), .dout_eop(dout_eop_nn),
        .dout_ready(dout_ready_nn), .stall_pct(stall_pct));
    // verdict and end of run, reached from the main sequence and from timeouts
    task automatic complete_run();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one comparison on a {sop, eop, data} word
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // offer one word from a falling edge and hold it until din_ready takes it
    task automatic send(input logic [7:0] d, input logic s, input logic e);
        int n;
        din_data = d;
        din_sop = s;
        din_eop = e;
        din_valid = 1'h1;
        for (n = 0; n < 20000; n++)
        begin
            if ((use_nn ? din_ready_nn : din_ready) === 1'h1)
                break;
            @(negedge mclk);
        end
        if (n == 20000)
        begin
            mismatches++;
            $display("BAD %0t input never accepted", $time);
            complete_run();
        end
        @(negedge mclk);
    endtask
    // released input: data shows the inverse of its last value, not a stale word
    task automatic idle();
        din_valid = 1'h0;
        din_sop = 1'h0;
        din_eop = 1'h0;
        din_data = ~din_data;
    endtask
    // expected bilinear pixel, right and bottom neighbours clamped at the edge
    function automatic logic [7:0] exp_px(int i, int j);
        int ii, jj, ei, ej, i1, j1, s;
        ii = (i * wi) / wo;
        jj = (j * hi) / ho;
        ei = ((i * wi) % wo) * 16 / ((wi > wo) ? wi : wo);
        ej = ((j * hi) % ho) * 8 / ((hi > ho) ? hi : ho);
        i1 = (ii + 1 < wi) ? ii + 1 : wi - 1;
        j1 = (jj + 1 < hi) ? jj + 1 : hi - 1;
        s = img[jj * wi + ii] * (16 - ei) * (8 - ej) + img[jj * wi + i1] * ei * (8 - ej)
            + img[j1 * wi + ii] * (16 - ei) * ej + img[j1 * wi + i1] * ei * ej;
        return 8'(s >> 7);
    endfunction
    // expected nearest pixel: doubled numerators land on input pixel centres
    function automatic logic [7:0] exp_nn(int i, int j);
        return img[((2 * hi * j + hi) / (2 * ho)) * wi + (2 * wi * i + wi) / (2 * wo)];
    endfunction
    // control packet, optional foreign packet, video packet, then check what came out
    task automatic run_frame(input int w, input int h, input int ow, input int oh,
        input bit junk, input bit nn);
        int k, i, j, n;
        logic [9:0] g0;
        logic [7:0] e;
        logic [9:0] q[$]; // words that the selected sink accepted
        use_nn = nn;
        wi = w;
        hi = h;
        wo = ow;
        ho = oh;
        cfg_out_w = ow[15:0];
        cfg_out_h = oh[15:0];
        SINK.got.delete();
        SINKN.got.delete();
        send(8'h0F, 1'h1, 1'h0);
        send(w[15:8], 1'h0, 1'h0);
        send(w[7:0], 1'h0, 1'h0);
        send(h[15:8], 1'h0, 1'h0);
        send(h[7:0], 1'h0, 1'h1);
        if (junk)
        begin
            send(8'h05, 1'h1, 1'h0);
            send(8'hAA, 1'h0, 1'h0);
            send(8'h55, 1'h0, 1'h1);
        end
        send(8'h00, 1'h1, 1'h0);
        for (k = 0; k < w * h; k++)
        begin
            img[k] = ($urandom % 4 == 0) ? 8'hFF : 8'($urandom);
            send(img[k], 1'h0, k == w * h - 1);
        end
        idle();
        for (n = 0; n < 20000 && (nn ? SINKN.got.size() : SINK.got.size()) < 6 + ow * oh; n++)
            @(negedge mclk);
        repeat (4) @(negedge mclk);
        if (nn)
            q = SINKN.got;
        else
            q = SINK.got;
        if (q.size() != 6 + ow * oh)
        begin
            mismatches++;
            $display("BAD %0t output word count %0d", $time, q.size());
            complete_run();
        end
        g0 = q[0];
        chk({g0[9:8], 4'h0, g0[3:0]}, {2'h2, 4'h0, 4'hF}, "ctrl head");
        chk(q[1], {2'h0, ow[15:8]}, "out w hi");
        chk(q[2], {2'h0, ow[7:0]}, "out w lo");
        chk(q[3], {2'h0, oh[15:8]}, "out h hi");
        chk(q[4], {2'h1, oh[7:0]}, "out h lo");
        chk(q[5], {2'h2, 8'h00}, "video head");
        for (j = 0; j < oh; j++)
            for (i = 0; i < ow; i++)
            begin
                k = 6 + j * ow + i;
                e = nn ? exp_nn(i, j) : exp_px(i, j);
                chk(q[k], {1'h0, k == 5 + ow * oh, e}, "pixel");
            end
    endtask
    // main sequence: corner sizes, random sizes under back-pressure, reset in mid-run
    initial
    begin
        int f;
        void'($urandom(32'hF928));
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        srst = 1'h0;
        @(negedge mclk);
        for (f = 0; f < 6; f++)
        begin
            stall_pct = (f % 2) ? 8'h28 : 8'h00;
            run_frame(tw[f], th[f], tow[f], toh[f], f == 2, 1'b0);
            run_frame(tw[f], th[f], tow[f], toh[f], f == 2, 1'b1);
        end
        for (f = 0; f < 6; f++)
        begin
            stall_pct = 8'($urandom % 60);
            run_frame(1 + $urandom % 8, 1 + $urandom % 8, 1 + $urandom % 8,
                1 + $urandom % 8, f == 3, f[0]);
        end
        send(8'h0F, 1'h1, 1'h0);
        srst = 1'h1;
        idle();
        repeat (2) @(negedge mclk);
        chk({dout_valid, din_ready, dout_valid_nn, din_ready_nn}, 4'h0, "in reset");
        srst = 1'h0;
        @(negedge mclk);
        stall_pct = 8'h00;
        run_frame(2, 1, 2, 1, 1'b0, 1'b0);
        run_frame(2, 1, 2, 1, 1'b0, 1'b1);
        complete_run();
    end
endmodule // video_frame_scaler_tb
